// file: src/mecc_cfg.svh
// constants of the control change codec: offsets, codes, values, resets
// assumes inclusion by bare name from the package and the design
`ifndef MECC_CFG_SVH
`define MECC_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define MECC_OFF_CTRL 8'h00
`define MECC_OFF_KNOB 8'h04
`define MECC_OFF_TMASK 8'h08
`define MECC_OFF_EN 8'h0C
`define MECC_OFF_OSC 8'h10
`define MECC_OFF_STAT 8'h14
// ****************************************
// reset values
// ****************************************
`define MECC_RST_CTRL 32'h0000_0000
`define MECC_RST_KNOB 32'h1514_1311
`define MECC_RST_TMASK 32'h0000_0000
`define MECC_RST_EN 32'h0000_03FF
`define MECC_RST_OSC 32'h0000_7F7F
// ****************************************
// message codes and controller numbers
// ****************************************
`define MECC_STATUS_CC 4'hB
`define MECC_CC_FOOT 7'h04
`define MECC_CC_EFF1 7'h0C
`define MECC_CC_EFF2 7'h0D
`define MECC_CC_RIBBON 7'h10
`define MECC_CC_SLIDER 7'h12
`define MECC_CC_DAMPER 7'h40
`define MECC_CC_SOST 7'h42
`define MECC_CC_SOFT 7'h43
`define MECC_CC_SW1 7'h50
`define MECC_CC_SW2 7'h51
`define MECC_CC_FSW 7'h52
`define MECC_CC_SEND2 7'h5B
`define MECC_CC_IFX 7'h5C
`define MECC_CC_SEND1 7'h5D
`define MECC_CC_MFX 7'h5E
`define MECC_CC_TFX 7'h5F
`define MECC_CC_MAX 7'h77
`define MECC_VAL_ON 7'h7F
`define MECC_VAL_OFF 7'h00
`define MECC_RESP_OK 2'h0
`define MECC_RESP_ERR 2'h2
`endif

// file: src/mecc_pkg.sv
// types of the control change codec
// assumes the constants header is on the include path
`include "mecc_cfg.svh"
package mecc_pkg;
  typedef enum logic [1:0] {
    MECC_RX_IDLE = 2'b00,
    MECC_RX_STAT = 2'b01,
    MECC_RX_NUM = 2'b10
  } mecc_rx_t;
  typedef enum logic [1:0] {
    MECC_PROG = 2'b00,
    MECC_COMBI = 2'b01,
    MECC_SEQ = 2'b10
  } mecc_mode_t;
endpackage : mecc_pkg

// file: src/mecc_codec.sv
// control change codec: encodes local controls, decodes received messages
// assumes a byte stream link, one clock, synchronous active low reset
`include "mecc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mecc_codec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic ev_valid,
  input wire logic [3:0] ev_src,
  input wire logic [6:0] ev_value,
  output logic ev_ready,
  output logic mod_valid,
  output logic [6:0] mod_cc,
  output logic [6:0] mod_value,
  output logic [6:0] damper_level,
  output logic sostenuto_on,
  output logic soft_on,
  output logic [2:0] switch_on,
  output logic [6:0] send1_level,
  output logic [6:0] send2_level,
  output logic [2:0] group_off
);
  // ****************************************
  // registers and state
  // ****************************************
  logic [31:0] ctrl_reg, knob_reg, tmask_reg, en_reg, osc_reg;
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  mecc_pkg::mecc_rx_t rx_st_reg;
  logic [3:0] rx_ch_reg;
  logic [6:0] rx_num_reg, rx_cc_reg, rx_val_reg;
  logic rx_go_reg;
  logic ev_pend_reg, ev_tx_reg;
  logic [6:0] ev_cc_reg, ev_val_reg;
  logic [2:0] grp_pend_reg, grp_done;
  logic [1:0] tx_cnt_reg, grp_sel;
  logic [15:0] tx_rest_reg;
  logic [6:0] send1_raw_reg, send2_raw_reg;
  logic [3:0] gch;
  logic prog_mode, ev_fire, app_go, do_wr;
  logic [6:0] app_cc, app_val, ev_cc_next, ev_val_next;
  logic ev_ok_next;
  logic [31:0] wr_merged;
  assign gch = ctrl_reg[3:0];
  assign prog_mode = ctrl_reg[5:4] == mecc_pkg::MECC_PROG;
  // ****************************************
  // helper functions
  // ****************************************
  // enable class bit guarding a controller, true when unguarded
  function automatic logic cls_ok(input logic [6:0] cc,
                                  input logic [31:0] en,
                                  input logic [31:0] kn);
    logic r;
    r = 1'b1;
    case (cc)
      `MECC_CC_FOOT: r = en[0];
      `MECC_CC_DAMPER: r = en[1];
      `MECC_CC_SW1: r = en[2];
      `MECC_CC_SW2: r = en[3];
      `MECC_CC_FSW: r = en[4];
      `MECC_CC_RIBBON: r = en[6];
      `MECC_CC_SEND1, `MECC_CC_SEND2: r = en[7];
      `MECC_CC_EFF1, `MECC_CC_EFF2: r = en[8];
      `MECC_CC_SOST, `MECC_CC_SOFT: r = en[9];
      default: r = 1'b1;
    endcase
    if (cc == kn[6:0] || cc == kn[14:8] || cc == kn[22:16] ||
        cc == kn[30:24]) begin
      r = en[5];
    end
    return r;
  endfunction : cls_ok
  // scaled send level in combi/seq, raw in program mode
  function automatic logic [6:0] send_eff(input logic [6:0] raw,
                                          input logic [6:0] osc,
                                          input logic prog);
    logic [13:0] p;
    p = raw * osc;
    return prog ? raw : p[13:7];
  endfunction : send_eff
  // clamp a knob assignment to the highest allowed controller
  function automatic logic [6:0] knob_lim(input logic [6:0] v);
    return (v > `MECC_CC_MAX) ? `MECC_CC_MAX : v;
  endfunction : knob_lim
  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
  always_comb begin
    wr_merged = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      wr_merged[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : 8'h00;
    end
  end
  // address and data latch in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MECC_RESP_OK;
    end else begin
      s_axi_awready <= !aw_got_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `MECC_OFF_CTRL, `MECC_OFF_KNOB, `MECC_OFF_TMASK,
          `MECC_OFF_EN, `MECC_OFF_OSC: s_axi_bresp <= `MECC_RESP_OK;
          default: s_axi_bresp <= `MECC_RESP_ERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // software registers, unstrobed bytes written as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `MECC_RST_CTRL;
      knob_reg <= `MECC_RST_KNOB;
      tmask_reg <= `MECC_RST_TMASK;
      en_reg <= `MECC_RST_EN;
      osc_reg <= `MECC_RST_OSC;
    end else if (do_wr) begin
      case (aw_addr_reg)
        `MECC_OFF_CTRL: ctrl_reg <= {20'h00000, wr_merged[11:0]};
        `MECC_OFF_KNOB: begin
          knob_reg <= {1'b0, knob_lim(wr_merged[30:24]),
                       1'b0, knob_lim(wr_merged[22:16]),
                       1'b0, knob_lim(wr_merged[14:8]),
                       1'b0, knob_lim(wr_merged[6:0])};
        end
        `MECC_OFF_TMASK: tmask_reg <= {16'h0000, wr_merged[15:0]};
        `MECC_OFF_EN: en_reg <= {22'h000000, wr_merged[9:0]};
        `MECC_OFF_OSC: osc_reg <= {17'h00000, wr_merged[14:8],
                                   1'b0, wr_merged[6:0]};
        default: ;
      endcase
    end
  end
  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MECC_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MECC_RESP_OK;
        case (s_axi_araddr)
          `MECC_OFF_CTRL: s_axi_rdata <= ctrl_reg;
          `MECC_OFF_KNOB: s_axi_rdata <= knob_reg;
          `MECC_OFF_TMASK: s_axi_rdata <= tmask_reg;
          `MECC_OFF_EN: s_axi_rdata <= en_reg;
          `MECC_OFF_OSC: s_axi_rdata <= osc_reg;
          `MECC_OFF_STAT: begin
            s_axi_rdata <= {1'b0, send2_level, 1'b0, send1_level,
                            1'b0, damper_level, switch_on, soft_on,
                            sostenuto_on, group_off};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MECC_RESP_ERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // receive parser
  // ****************************************
  // status, number, value with running status kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_reg <= mecc_pkg::MECC_RX_IDLE;
      rx_ch_reg <= 4'h0;
      rx_num_reg <= 7'h00;
      rx_cc_reg <= 7'h00;
      rx_val_reg <= 7'h00;
      rx_go_reg <= 1'b0;
    end else begin
      rx_go_reg <= 1'b0;
      if (rx_valid) begin
        if (rx_byte[7]) begin
          rx_ch_reg <= rx_byte[3:0];
          rx_st_reg <= (rx_byte[7:4] == `MECC_STATUS_CC) ?
                       mecc_pkg::MECC_RX_STAT : mecc_pkg::MECC_RX_IDLE;
        end else begin
          case (rx_st_reg)
            mecc_pkg::MECC_RX_STAT: begin
              rx_num_reg <= rx_byte[6:0];
              rx_st_reg <= mecc_pkg::MECC_RX_NUM;
            end
            mecc_pkg::MECC_RX_NUM: begin
              rx_cc_reg <= rx_num_reg;
              rx_val_reg <= rx_byte[6:0];
              rx_st_reg <= mecc_pkg::MECC_RX_STAT;
              if (rx_num_reg == `MECC_CC_IFX || rx_num_reg == `MECC_CC_MFX ||
                  rx_num_reg == `MECC_CC_TFX) begin
                rx_go_reg <= rx_ch_reg == gch;
              end else begin
                rx_go_reg <= rx_ch_reg == gch ||
                             (!prog_mode && tmask_reg[rx_ch_reg] &&
                              cls_ok(rx_num_reg, en_reg, knob_reg));
              end
            end
            default: rx_st_reg <= mecc_pkg::MECC_RX_IDLE;
          endcase
        end
      end
    end
  end
  // ****************************************
  // local controller events
  // ****************************************
  // controller number, value and send permission of a local source
  always_comb begin
    ev_cc_next = `MECC_CC_FOOT;
    ev_val_next = ev_value;
    ev_ok_next = 1'b1;
    case (ev_src)
      4'h0: ev_ok_next = ctrl_reg[7];
      4'h1: ev_cc_next = `MECC_CC_DAMPER;
      4'h2: ev_cc_next = `MECC_CC_SW1;
      4'h3: ev_cc_next = `MECC_CC_SW2;
      4'h4: ev_cc_next = `MECC_CC_FSW;
      4'h5: ev_cc_next = `MECC_CC_SOFT;
      4'h6: begin
        ev_cc_next = `MECC_CC_SLIDER;
        ev_ok_next = ctrl_reg[6];
      end
      4'h7: ev_cc_next = knob_reg[6:0];
      4'h8: ev_cc_next = knob_reg[14:8];
      4'h9: ev_cc_next = knob_reg[22:16];
      4'hA: ev_cc_next = knob_reg[30:24];
      4'hB: ev_cc_next = `MECC_CC_EFF1;
      4'hC: ev_cc_next = `MECC_CC_EFF2;
      4'hD: ev_cc_next = `MECC_CC_SEND1;
      4'hE: ev_cc_next = `MECC_CC_SEND2;
      default: ev_cc_next = `MECC_CC_SOST;
    endcase
    if (ev_src >= 4'h7 && ev_src <= 4'hA) begin
      ev_ok_next = ctrl_reg[11];
    end
    if ((ev_src >= 4'h2 && ev_src <= 4'h4) || ev_src == 4'hF) begin
      ev_val_next = (ev_value != 7'h00) ? `MECC_VAL_ON : `MECC_VAL_OFF;
    end
    if (ev_src == 4'h5) begin
      ev_val_next = `MECC_VAL_ON;
    end
  end
  assign ev_fire = ev_pend_reg && !rx_go_reg && tx_cnt_reg == 2'd0 &&
                   grp_pend_reg == 3'b000;
  // highest pending group first, only that one cleared as it starts
  assign grp_sel = grp_pend_reg[2] ? 2'd2 : {1'b0, grp_pend_reg[1]};
  assign grp_done = (tx_cnt_reg == 2'd0) ? 3'b001 << grp_sel : 3'b000;
  // hold one event until the encoder and the apply path are free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_pend_reg <= 1'b0;
      ev_tx_reg <= 1'b0;
      ev_cc_reg <= 7'h00;
      ev_val_reg <= 7'h00;
      ev_ready <= 1'b0;
    end else begin
      if (ev_valid && ev_ready) begin
        ev_pend_reg <= 1'b1;
        ev_ready <= 1'b0;
        ev_cc_reg <= ev_cc_next;
        ev_val_reg <= ev_val_next;
        ev_tx_reg <= ev_ok_next && (prog_mode ||
                     cls_ok(ev_cc_next, en_reg, knob_reg));
      end else if (ev_fire) begin
        ev_pend_reg <= 1'b0;
      end else begin
        ev_ready <= !ev_pend_reg;
      end
    end
  end
  // ****************************************
  // transmit encoder
  // ****************************************
  // group messages first, then the held local event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_pend_reg <= 3'b000;
      tx_cnt_reg <= 2'd0;
      tx_rest_reg <= 16'h0000;
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        tx_valid <= tx_cnt_reg != 2'd1;
        tx_byte <= tx_rest_reg[15:8];
        tx_rest_reg <= {tx_rest_reg[7:0], 8'h00};
        tx_cnt_reg <= tx_cnt_reg - 2'd1;
      end else if (tx_cnt_reg == 2'd0 && grp_pend_reg != 3'b000) begin
        tx_valid <= 1'b1;
        tx_cnt_reg <= 2'd3;
        tx_byte <= {`MECC_STATUS_CC, gch};
        grp_pend_reg <= grp_pend_reg & ~grp_done;
        tx_rest_reg[15:8] <= {1'b0, grp_sel[1] ? `MECC_CC_TFX :
                              grp_sel[0] ? `MECC_CC_MFX : `MECC_CC_IFX};
        tx_rest_reg[7:0] <= {1'b0, ctrl_reg[8 + grp_sel] ?
                             `MECC_VAL_OFF : `MECC_VAL_ON};
      end else if (ev_fire && ev_tx_reg) begin
        tx_valid <= 1'b1;
        tx_cnt_reg <= 2'd3;
        tx_byte <= {`MECC_STATUS_CC, gch};
        tx_rest_reg <= {1'b0, ev_cc_reg, 1'b0, ev_val_reg};
      end
      if (do_wr && aw_addr_reg == `MECC_OFF_CTRL) begin
        grp_pend_reg <= (grp_pend_reg & ~grp_done) |
                        (ctrl_reg[10:8] ^ wr_merged[10:8]);
      end
    end
  end
  // ****************************************
  // apply path shared by received and local controls
  // ****************************************
  assign app_go = rx_go_reg || ev_fire;
  assign app_cc = rx_go_reg ? rx_cc_reg : ev_cc_reg;
  assign app_val = rx_go_reg ? rx_val_reg : ev_val_reg;
  // controller state and modulation pulse toward the sound engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_valid <= 1'b0;
      mod_cc <= 7'h00;
      mod_value <= 7'h00;
      damper_level <= 7'h00;
      sostenuto_on <= 1'b0;
      soft_on <= 1'b0;
      switch_on <= 3'b000;
      send1_raw_reg <= 7'h00;
      send2_raw_reg <= 7'h00;
      group_off <= 3'b000;
    end else begin
      mod_valid <= app_go;
      if (app_go) begin
        mod_cc <= app_cc;
        mod_value <= app_val;
        case (app_cc)
          `MECC_CC_DAMPER: damper_level <= app_val;
          `MECC_CC_SOST: sostenuto_on <= app_val[6];
          `MECC_CC_SOFT: soft_on <= app_val[6];
          `MECC_CC_SW1: switch_on[0] <= app_val[6];
          `MECC_CC_SW2: switch_on[1] <= app_val[6];
          `MECC_CC_FSW: switch_on[2] <= app_val[6];
          `MECC_CC_SEND1: send1_raw_reg <= app_val;
          `MECC_CC_SEND2: send2_raw_reg <= app_val;
          `MECC_CC_IFX: group_off[0] <= app_val == 7'h00;
          `MECC_CC_MFX: group_off[1] <= app_val == 7'h00;
          `MECC_CC_TFX: group_off[2] <= app_val == 7'h00;
          default: ;
        endcase
      end
      if (do_wr && aw_addr_reg == `MECC_OFF_CTRL) begin
        group_off <= wr_merged[10:8];
      end
    end
  end
  // effective send levels toward the two master effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send1_level <= 7'h00;
      send2_level <= 7'h00;
    end else begin
      send1_level <= send_eff(send1_raw_reg, osc_reg[6:0], prog_mode);
      send2_level <= send_eff(send2_raw_reg, osc_reg[14:8], prog_mode);
    end
  end
endmodule : mecc_codec
`default_nettype wire

// file: testbench/mecc_codec_props.sv
// checker of the control change codec, watching its ports only
// assumes binding onto mecc_codec, one clock, sync active low reset
`timescale 1ns/1ns
`default_nettype none
module mecc_codec_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic mod_valid,
  input wire logic [6:0] mod_cc,
  input wire logic [6:0] mod_value,
  input wire logic [6:0] damper_level,
  input wire logic sostenuto_on,
  input wire logic soft_on,
  input wire logic [2:0] switch_on,
  input wire logic [2:0] group_off
);
  logic [1:0] pos_reg;
  logic [6:0] cc_reg;
  // ****
  // byte position inside an outgoing message
  // ****
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pos_reg <= 2'h0;
    else if (tx_valid && tx_ready)
      pos_reg <= (pos_reg == 2'h2) ? 2'h0 : pos_reg + 2'h1;
  end
  // number byte of the message under way
  always_ff @(posedge aclk) begin
    if (tx_valid && tx_ready && pos_reg == 2'h1)
      cc_reg <= tx_byte[6:0];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("tx byte dropped");
  a_tx_status: assert property (tx_valid && pos_reg == 2'h0 |->
    tx_byte[7:4] == 4'hB) else $error("bad status byte");
  a_tx_data7: assert property (tx_valid && pos_reg != 2'h0 |->
    !tx_byte[7]) else $error("data byte with bit 7");
  a_switch_value: assert property (tx_valid && pos_reg == 2'h2 &&
    cc_reg inside {7'h50, 7'h51, 7'h52, 7'h5C, 7'h5E, 7'h5F} |->
    tx_byte inside {8'h7F, 8'h00}) else $error("switch value not 7F/00");
  a_sost_thresh: assert property (mod_valid && mod_cc == 7'h42 |->
    sostenuto_on == mod_value[6]) else $error("sostenuto level");
  a_soft_thresh: assert property (mod_valid && mod_cc == 7'h43 |->
    soft_on == mod_value[6]) else $error("soft pedal level");
  a_switch_thresh: assert property (mod_valid && mod_cc == 7'h50 |->
    switch_on[0] == mod_value[6]) else $error("switch one level");
  a_damper_level: assert property (mod_valid && mod_cc == 7'h40 |->
    damper_level == mod_value) else $error("damper level");
  a_group_total: assert property (mod_valid && mod_cc == 7'h5F |->
    group_off[2] == (mod_value == 7'h00)) else $error("total group");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
endmodule : mecc_codec_props
bind mecc_codec mecc_codec_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .mod_valid(mod_valid), .mod_cc(mod_cc),
  .mod_value(mod_value), .damper_level(damper_level),
  .sostenuto_on(sostenuto_on), .soft_on(soft_on), .switch_on(switch_on),
  .group_off(group_off));
`default_nettype wire

// file: testbench/mecc_link_model.sv
// far side of the serial link: sends messages, takes sent bytes
// assumes the codec clock, sync active low reset
`timescale 1ns/1ns
`default_nettype none
module mecc_link_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  input wire logic slow
);
  logic [7:0] got_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hFF;
  end
  // ****
  // one message: status, number, value
  // ****
  task send(input logic [7:0] st, input logic [7:0] nb, input logic [7:0] vl);
    logic [7:0] m[3];
    int i;
    m = '{st, nb, vl};
    for (i = 0; i < 3; i++) begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_byte <= m[i];
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_byte <= ~m[i]; // line not idle at old value
    end
  endtask : send
  // taker of sent bytes, stalls every other cycle when slow
  always @(posedge aclk) begin
    if (!aresetn)
      tx_ready <= 1'b0;
    else
      tx_ready <= slow ? ~tx_ready : 1'b1;
    if (aresetn && tx_valid && tx_ready)
      got_q.push_back(tx_byte);
  end
endmodule : mecc_link_model
`default_nettype wire

// file: testbench/mecc_codec_test.sv
// testbench of the control change codec over its register bus and link
// assumes the link model and the checker compiled beforehand
`include "mecc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module mecc_codec_test;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_rvalid, rx_valid, tx_valid, tx_ready, mod_valid;
  logic [7:0] rx_byte, tx_byte;
  logic ev_valid = 1'b0, ev_ready, sostenuto_on, soft_on;
  logic [3:0] ev_src = 4'h0;
  logic [6:0] ev_value = 7'h00, mod_cc, mod_value, damper_level;
  logic [6:0] send1_level, send2_level;
  logic [2:0] switch_on, group_off;
  logic [6:0] ev_cc[16] = '{7'h04, 7'h40, 7'h50, 7'h51, 7'h52, 7'h43,
    7'h12, 7'h00, 7'h13, 7'h77, 7'h15, 7'h0C, 7'h0D, 7'h5D, 7'h5B, 7'h42};
  logic [7:0] grp[3] = '{8'h5C, 8'h5E, 8'h5F};
  logic [31:0] rd;
  logic [1:0] rs;
  int n_mismatch = 0, checks_done = 0, k;
  mecc_codec uut (.*);
  mecc_link_model lnk (.*);
  always #5 aclk = ~aclk;
  // ****
  // compare, verdict and timeout
  // ****
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task tmo;
    n_mismatch++;
    $display("wrong value wait exp answer got none");
    stop_test();
  endtask : tmo
  // ****
  // register bus master
  // ****
  task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (i == 40) tmo();
    chk("bresp", e, rs);
  endtask : wr_chk
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (i == 40) tmo();
    chk("rdata", e, rd);
    chk("rresp", er, rs);
  endtask : rd_chk
  // ****
  // link and local control helpers
  // ****
  task msg(input logic [7:0] s, input logic [7:0] n, input logic [7:0] v);
    lnk.send(s, n, v);
    repeat (6) @(posedge aclk);
  endtask : msg
  task ev(input logic [3:0] s, input logic [6:0] v);
    int i;
    @(posedge aclk);
    ev_valid <= 1'b1;
    ev_src <= s;
    ev_value <= v;
    for (i = 0; i < 40 && !ev_ready; i++) @(posedge aclk);
    @(posedge aclk);
    ev_valid <= 1'b0;
    if (i == 40) tmo();
  endtask : ev
  task tx3(input logic [7:0] c, input logic [7:0] v);
    int i;
    for (i = 0; i < 300 && lnk.got_q.size() < 3; i++) @(posedge aclk);
    if (i == 300) tmo();
    chk("tx status", {`MECC_STATUS_CC, 4'h3}, lnk.got_q.pop_front());
    chk("tx number", c, lnk.got_q.pop_front());
    chk("tx value", v, lnk.got_q.pop_front());
  endtask : tx3
  // ****
  // main sequence
  // ****
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`MECC_OFF_CTRL, `MECC_RST_CTRL, `MECC_RESP_OK);
    rd_chk(`MECC_OFF_KNOB, `MECC_RST_KNOB, `MECC_RESP_OK);
    rd_chk(`MECC_OFF_TMASK, `MECC_RST_TMASK, `MECC_RESP_OK);
    rd_chk(`MECC_OFF_EN, `MECC_RST_EN, `MECC_RESP_OK);
    rd_chk(`MECC_OFF_OSC, `MECC_RST_OSC, `MECC_RESP_OK);
    rd_chk(8'h18, 32'h0, `MECC_RESP_ERR);
    wr_chk(8'h18, 32'hFFFF_FFFF, `MECC_RESP_ERR);
    wr_chk(`MECC_OFF_STAT, 32'hFFFF_FFFF, `MECC_RESP_ERR);
    wr_chk(`MECC_OFF_KNOB, 32'h157A_1300, `MECC_RESP_OK);
    rd_chk(`MECC_OFF_KNOB, 32'h1577_1300, `MECC_RESP_OK);
    wr_chk(`MECC_OFF_CTRL, 32'h0000_08C3, `MECC_RESP_OK);
    // every local source, slow taker on the far side
    slow <= 1'b1;
    for (k = 0; k < 16; k++) begin
      ev(k[3:0], 7'h05);
      tx3(ev_cc[k], (k inside {2, 3, 4, 5, 15}) ? 8'h7F : 8'h05);
    end
    chk("damper", 7'h05, damper_level);
    chk("switches", 3'b111, switch_on);
    chk("soft", 1'b1, soft_on);
    chk("send1", 7'h05, send1_level);
    chk("send2", 7'h05, send2_level);
    ev(4'h2, 7'h00);
    tx3(8'h50, 8'h00);
    wr_chk(`MECC_OFF_CTRL, 32'h0000_0003, `MECC_RESP_OK);
    ev(4'h6, 7'h09);
    ev(4'h0, 7'h09);
    repeat (30) @(posedge aclk);
    chk("tx count", 0, lnk.got_q.size());
    // received controls on the global channel, one on channel 5 ignored
    msg(8'hB3, 8'h42, 8'h3F);
    chk("sost", 1'b0, sostenuto_on);
    msg(8'hB3, 8'h42, 8'h40);
    chk("sost", 1'b1, sostenuto_on);
    msg(8'hB3, 8'h43, 8'h3F);
    chk("soft", 1'b0, soft_on);
    msg(8'hB3, 8'h50, 8'h40);
    chk("switch", 3'b111, switch_on);
    msg(8'hB3, 8'h40, 8'h2A);
    chk("damper", 7'h2A, damper_level);
    msg(8'hB3, 8'h5D, 8'h40);
    chk("send1", 7'h40, send1_level);
    msg(8'hB3, 8'h5B, 8'h21);
    chk("send2", 7'h21, send2_level);
    msg(8'hB5, 8'h40, 8'h11);
    chk("damper", 7'h2A, damper_level);
    msg(8'hB3, 8'h10, 8'h55);
    chk("mod", {7'h10, 7'h55}, {mod_cc, mod_value});
    msg(8'hB3, 8'h58, 8'h21);
    chk("mod", {7'h58, 7'h21}, {mod_cc, mod_value});
    for (k = 0; k < 3; k++) begin
      msg(8'hB3, grp[k], 8'h00);
      chk("group", 3'b001 << k, group_off);
      msg(8'hB3, grp[k], 8'h01);
      chk("group", 3'b000, group_off);
    end
    // combination mode, timbre on channel 5
    wr_chk(`MECC_OFF_CTRL, 32'h0000_0013, `MECC_RESP_OK);
    wr_chk(`MECC_OFF_TMASK, 32'h0000_0020, `MECC_RESP_OK);
    wr_chk(`MECC_OFF_OSC, 32'h0000_4040, `MECC_RESP_OK);
    msg(8'hB5, 8'h5C, 8'h00);
    chk("group", 3'b000, group_off);
    msg(8'hB5, 8'h5D, 8'h7F);
    chk("send1", 7'h3F, send1_level);
    msg(8'hB5, 8'h40, 8'h11);
    chk("damper", 7'h11, damper_level);
    wr_chk(`MECC_OFF_EN, 32'h0000_03FD, `MECC_RESP_OK);
    msg(8'hB5, 8'h40, 8'h22);
    chk("damper", 7'h11, damper_level);
    // group disable settings sent highest first
    wr_chk(`MECC_OFF_CTRL, 32'h0000_0513, `MECC_RESP_OK);
    tx3(8'h5F, 8'h00);
    tx3(8'h5C, 8'h00);
    chk("group", 3'b101, group_off);
    wr_chk(`MECC_OFF_CTRL, 32'h0000_0013, `MECC_RESP_OK);
    tx3(8'h5F, 8'h7F);
    tx3(8'h5C, 8'h7F);
    stop_test();
  end
endmodule : mecc_codec_test
`default_nettype wire
